// ===== rtl/rcu_ctrl_status.sv
`timescale 1ns/1ns
module rcu_ctrl_status (
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  input  wire logic                        upgrade_shift_clock,
  input  wire logic                        link_rst_b,
  input  wire logic                        parallel_flash_scheme,
  input  wire logic                        set_factory_boot_instruction,
  input  wire logic [rcu_pkg::ADDR_W-1:0]  factory_boot_addr_in,
  input  wire logic                        fabric_reconfig_request,
  input  wire logic                        update_strobe,
  input  wire logic [rcu_pkg::CTRL_W-1:0]  update_data,
  input  wire logic                        config_reset_b,
  input  wire logic                        config_status_pin,
  input  wire logic                        configuration_complete_pin,
  input  wire logic                        crc_error,
  input  wire logic                        watchdog_timeout,
  input  wire logic                        image_load_done,
  input  wire logic                        image_valid,
  input  wire logic                        status_view_sel,
  output logic      [rcu_pkg::CTRL_W-1:0]  upgrade_control,
  output logic      [rcu_pkg::STAT_W-1:0]  upgrade_status,
  output logic      [rcu_pkg::ADDR_W-1:0]  boot_address,
  output logic      [rcu_pkg::WDC_W-1:0]   watchdog_count,
  output logic                             watchdog_enable_bit,
  output logic                             osc_startup_select,
  output logic                             image_load_start,
  output logic      [rcu_pkg::CAUSE_W-1:0] reconfig_cause,
  output logic      [1:0]                  master_state
);
  localparam int HW = $clog2(rcu_pkg::REQ_HOLD_CYC + 1);
  localparam logic [HW-1:0] HOLD_LAST = HW'(rcu_pkg::REQ_HOLD_CYC - 1);

  rcu_pkg::rcu_state_e             state;
  logic [rcu_pkg::CTRL_W-1:0]      ctrl;
  logic [rcu_pkg::ADDR_W-1:0]      factory_addr;
  logic [rcu_pkg::ADDR_W-1:0]      loaded_addr;
  logic [rcu_pkg::ADDR_W-1:0]      next_boot;
  logic [rcu_pkg::CAUSE_W-1:0]     next_cause;
  logic [1:0]                      pw_cnt;
  logic [HW-1:0]                   hold_cnt;
  logic                            req_fired;
  logic                            req_fire;
  logic                            err_any;
  logic                            early_fail;
  logic [4:0]                      sync_q;
  logic                            cfg_rst_s;
  logic                            stat_err_s;
  logic                            done_s;
  logic                            req_s;
  logic                            scheme_s;

  rcu_link_if lk ();

  // ------------------------------------------------------------
  // link side and crossings
  // ------------------------------------------------------------
  // update path on link clock
  rcu_link u_link (
    .upgrade_shift_clock     (upgrade_shift_clock),
    .link_rst_b              (link_rst_b),
    .update_strobe           (update_strobe),
    .update_data             (update_data),
    .fabric_reconfig_request (fabric_reconfig_request),
    .lk                      (lk.link)
  );

  // pins idle high for the two active-low inputs
  rcu_sync #(.WIDTH(5), .RST_VAL(5'h18)) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     ({config_reset_b, config_status_pin, configuration_complete_pin,
             lk.req_level, parallel_flash_scheme}),
    .q     (sync_q)
  );

  assign cfg_rst_s  = !sync_q[4];
  assign stat_err_s = !sync_q[3];
  assign done_s     = sync_q[2];
  assign req_s      = sync_q[1];
  assign scheme_s   = sync_q[0];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lk.factory_level <= 1'b0;
    end else begin
      lk.factory_level <= (state == rcu_pkg::RCU_ST_FACTORY);
    end
  end

  // ------------------------------------------------------------
  // request qualification
  // ------------------------------------------------------------
  // minimum request hold
  assign req_fire = req_s && (hold_cnt == HOLD_LAST) && !req_fired;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hold_cnt  <= '0;
      req_fired <= 1'b0;
    end else if (!req_s) begin
      hold_cnt  <= '0;
      req_fired <= 1'b0;
    end else begin
      if (hold_cnt != HOLD_LAST) begin
        hold_cnt <= hold_cnt + HW'(1);
      end
      if (req_fire) begin
        req_fired <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // cause priority and boot address
  // ------------------------------------------------------------
  // trigger cause, one-hot
  always_comb begin
    next_cause = '0;
    if (cfg_rst_s) begin
      next_cause[rcu_pkg::CZ_CFG] = 1'b1;
    end else if (crc_error) begin
      next_cause[rcu_pkg::CZ_CRC] = 1'b1;
    end else if (stat_err_s) begin
      next_cause[rcu_pkg::CZ_STATUS] = 1'b1;
    end else if (watchdog_timeout && state == rcu_pkg::RCU_ST_APP) begin
      next_cause[rcu_pkg::CZ_WDOG] = 1'b1;
    end else if (req_fire && state != rcu_pkg::RCU_ST_LOAD) begin
      next_cause[rcu_pkg::CZ_FABRIC] = 1'b1;
    end
  end

  assign err_any = |next_cause[rcu_pkg::CZ_CFG:rcu_pkg::CZ_WDOG];

  assign early_fail = ctrl[rcu_pkg::CB_EARLY] &&
                      ((done_s && !image_load_done) || (image_load_done && !image_valid));

  // a zero field means the factory page, wherever that sits
  // field plus two zero bits
  assign next_boot = (ctrl[rcu_pkg::CB_ADDR_HI:rcu_pkg::CB_ADDR_LO] == rcu_pkg::FIELD_ZERO) ?
                     factory_addr : {ctrl[rcu_pkg::CB_ADDR_HI:rcu_pkg::CB_ADDR_LO],
                                     rcu_pkg::ADDR_TAIL};

  // ------------------------------------------------------------
  // factory address
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      factory_addr <= rcu_pkg::SER_FACTORY_ADDR;
    end else if (state == rcu_pkg::RCU_ST_PWRUP) begin
      factory_addr <= scheme_s ? rcu_pkg::PAR_FACTORY_ADDR : rcu_pkg::SER_FACTORY_ADDR;
      if (set_factory_boot_instruction && scheme_s) begin
        factory_addr <= factory_boot_addr_in;
      end
    end else if (set_factory_boot_instruction && scheme_s) begin
      factory_addr <= factory_boot_addr_in;
    end
  end

  // ------------------------------------------------------------
  // master state and control register
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pw_cnt <= 2'h0;
    end else if (state == rcu_pkg::RCU_ST_PWRUP && pw_cnt != rcu_pkg::PW_LAST) begin
      pw_cnt <= pw_cnt + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state            <= rcu_pkg::RCU_ST_PWRUP;
      ctrl             <= rcu_pkg::CTRL_CLEAR;
      reconfig_cause   <= '0;
      loaded_addr      <= '0;
      image_load_start <= 1'b0;
    end else begin
      image_load_start <= 1'b0;
      unique case (state)
        rcu_pkg::RCU_ST_PWRUP: begin
          if (pw_cnt == rcu_pkg::PW_LAST) begin
            ctrl <= rcu_pkg::CTRL_CLEAR;
            ctrl[rcu_pkg::CB_ADDR_HI:rcu_pkg::CB_ADDR_LO] <= scheme_s ?
              rcu_pkg::PAR_FACTORY_ADDR[rcu_pkg::ADDR_W-1:2] :
              rcu_pkg::SER_FACTORY_ADDR[rcu_pkg::ADDR_W-1:2];
            state            <= rcu_pkg::RCU_ST_LOAD;
            image_load_start <= 1'b1;
          end
        end
        rcu_pkg::RCU_ST_LOAD: begin
          if (err_any) begin
            reconfig_cause   <= next_cause;
            ctrl             <= rcu_pkg::CTRL_CLEAR;
            image_load_start <= 1'b1;
          end else if (early_fail) begin
            ctrl             <= rcu_pkg::CTRL_CLEAR;
            image_load_start <= 1'b1;
          end else if (image_load_done) begin
            loaded_addr <= next_boot;
            state       <= (next_boot == factory_addr) ? rcu_pkg::RCU_ST_FACTORY :
                                                         rcu_pkg::RCU_ST_APP;
          end
        end
        rcu_pkg::RCU_ST_FACTORY,
        rcu_pkg::RCU_ST_APP: begin
          if (|next_cause) begin
            reconfig_cause   <= next_cause;
            state            <= rcu_pkg::RCU_ST_LOAD;
            image_load_start <= 1'b1;
            // only a factory request loads the update word
            ctrl <= (!err_any && state == rcu_pkg::RCU_ST_FACTORY) ? lk.upd_word :
                                                                    rcu_pkg::CTRL_CLEAR;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // registered outputs and status views
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      upgrade_control     <= rcu_pkg::CTRL_CLEAR;
      boot_address        <= '0;
      watchdog_count      <= '0;
      watchdog_enable_bit <= 1'b0;
      osc_startup_select  <= 1'b0;
      master_state        <= 2'h0;
      upgrade_status      <= '0;
    end else begin
      upgrade_control     <= ctrl;
      boot_address        <= next_boot;
      watchdog_count      <= {ctrl[rcu_pkg::CB_WDT_HI:0], rcu_pkg::WDT_TAIL};
      watchdog_enable_bit <= ctrl[rcu_pkg::CB_WDEN];
      osc_startup_select  <= ctrl[rcu_pkg::CB_OSC];
      master_state        <= state;
      if (state == rcu_pkg::RCU_ST_APP && !status_view_sel) begin
        upgrade_status <= {state, ctrl[rcu_pkg::CB_WDEN],
                           ctrl[rcu_pkg::CB_WDT_HI:0], rcu_pkg::WDT_TAIL};
      end else begin
        upgrade_status <= {state, rcu_pkg::STAT_PAD, loaded_addr};
      end
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_PWRUP_SERIAL: assert property (
    state == rcu_pkg::RCU_ST_PWRUP && pw_cnt == rcu_pkg::PW_LAST && !scheme_s
    |=> ctrl == rcu_pkg::CTRL_CLEAR ##1 boot_address == factory_addr)
    else $error("serial power-up boot address not zero");
  AST_PWRUP_PARALLEL: assert property (
    state == rcu_pkg::RCU_ST_PWRUP && pw_cnt == rcu_pkg::PW_LAST && scheme_s
    |=> ctrl[33:12] == 22'h004000 && state == rcu_pkg::RCU_ST_LOAD)
    else $error("parallel power-up boot field wrong");
  AST_FACTORY_OVERRIDE: assert property (
    set_factory_boot_instruction && scheme_s |=> factory_addr == $past(factory_boot_addr_in))
    else $error("factory address override not taken");
  AST_APP_NO_WRITE: assert property (
    state == rcu_pkg::RCU_ST_APP |=> ctrl == $past(ctrl) || ctrl == rcu_pkg::CTRL_CLEAR)
    else $error("control written from application");
  AST_WDOG_FORM: assert property (
    1'b1 |=> watchdog_count == {$past(ctrl[11:0]), 17'h10000})
    else $error("watchdog count malformed");
  AST_BOOT_FORM: assert property (
    ctrl[33:12] != 22'h0 |=> boot_address == {$past(ctrl[33:12]), 2'h0})
    else $error("boot address malformed");
  AST_EARLY_FAIL: assert property (
    state == rcu_pkg::RCU_ST_LOAD && !err_any && ctrl[37] && image_load_done && !image_valid
    |=> ctrl == rcu_pkg::CTRL_CLEAR && image_load_start && state == rcu_pkg::RCU_ST_LOAD)
    else $error("invalid image did not fall back");
  AST_STATE_BITS: assert property (
    1'b1 |=> upgrade_status[31:30] == $past(state) && master_state == $past(state))
    else $error("status state bits wrong");
  AST_FACTORY_VIEW: assert property (
    state == rcu_pkg::RCU_ST_FACTORY |=> upgrade_status[29:0] == {6'h00, $past(loaded_addr)})
    else $error("factory view wrong");
  AST_REQ_HOLD: assert property (
    req_fire |-> $past(req_s, rcu_pkg::REQ_HOLD_CYC - 1))
    else $error("request acted on before hold time");
  AST_ERR_CLEAR: assert property (
    state == rcu_pkg::RCU_ST_APP && err_any
    |=> ctrl == rcu_pkg::CTRL_CLEAR ##1 reconfig_cause != 5'h00)
    else $error("error did not clear control");

  COV_FACTORY_REQ: cover property (state == rcu_pkg::RCU_ST_FACTORY && req_fire);
  COV_APP_WDOG: cover property (state == rcu_pkg::RCU_ST_APP && next_cause[1]);
  COV_EARLY_FAIL: cover property (state == rcu_pkg::RCU_ST_LOAD && early_fail);
  COV_REACH_APP: cover property (state == rcu_pkg::RCU_ST_LOAD ##1 state == rcu_pkg::RCU_ST_APP);
endmodule : rcu_ctrl_status

// ===== rtl/rcu_pkg.sv
package rcu_pkg;
  // ------------------------------------------------------------
  // register layout
  // ------------------------------------------------------------
  localparam int CTRL_W     = 39;
  localparam int STAT_W     = 32;
  localparam int ADDR_W     = 24;
  localparam int FIELD_W    = 22;
  localparam int WDT_W      = 12;
  localparam int WDC_W      = 29;
  localparam int CAUSE_W    = 5;
  localparam int CB_EARLY   = 37;
  localparam int CB_OSC     = 36;
  localparam int CB_WDEN    = 35;
  localparam int CB_ADDR_HI = 33;
  localparam int CB_ADDR_LO = 12;
  localparam int CB_WDT_HI  = 11;
  localparam int SB_ST_HI   = 31;
  localparam int SB_ST_LO   = 30;
  localparam int SB_WDEN    = 29;

  localparam logic [CTRL_W-1:0] CTRL_CLEAR       = 39'h0;
  localparam logic [16:0]       WDT_TAIL         = 17'h10000;
  localparam logic [1:0]        ADDR_TAIL        = 2'h0;
  localparam logic [5:0]        STAT_PAD         = 6'h00;
  localparam logic [ADDR_W-1:0] SER_FACTORY_ADDR = 24'h000000;
  localparam logic [ADDR_W-1:0] PAR_FACTORY_ADDR = 24'h010000;
  localparam logic [FIELD_W-1:0] FIELD_ZERO      = 22'h0;

  // one-hot cause positions, higher position wins a tie
  localparam int CZ_CFG    = 4;
  localparam int CZ_CRC    = 3;
  localparam int CZ_STATUS = 2;
  localparam int CZ_WDOG   = 1;
  localparam int CZ_FABRIC = 0;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int REQ_HOLD_NS   = 250;
  localparam int REQ_HOLD_CYC  = (REQ_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] PW_LAST = 2'h3;

  typedef enum logic [1:0] {
    RCU_ST_LOAD    = 2'b00,
    RCU_ST_FACTORY = 2'b01,
    RCU_ST_APP     = 2'b10,
    RCU_ST_PWRUP   = 2'b11
  } rcu_state_e;
endpackage : rcu_pkg

// ===== rtl/rcu_link_if.sv
`timescale 1ns/1ns
interface rcu_link_if;
  logic [rcu_pkg::CTRL_W-1:0] upd_word;
  logic                       req_level;
  logic                       factory_level;
  modport link (output upd_word, output req_level, input factory_level);
  modport core (input upd_word, input req_level, output factory_level);
endinterface : rcu_link_if

// ===== rtl/rcu_sync.sv
`timescale 1ns/1ns
module rcu_sync #(
  parameter int                 WIDTH   = 1,
  parameter logic [WIDTH-1:0]   RST_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stage1 <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      stage1 <= d;
      q      <= stage1;
    end
  end
endmodule : rcu_sync

// ===== rtl/rcu_link.sv
`timescale 1ns/1ns
module rcu_link (
  input  wire logic                       upgrade_shift_clock,
  input  wire logic                       link_rst_b,
  input  wire logic                       update_strobe,
  input  wire logic [rcu_pkg::CTRL_W-1:0] update_data,
  input  wire logic                       fabric_reconfig_request,
  rcu_link_if.link                        lk
);
  logic fac_s1;
  logic fac_s2;

  always_ff @(posedge upgrade_shift_clock) begin
    if (!link_rst_b) begin
      fac_s1 <= 1'b0;
      fac_s2 <= 1'b0;
    end else begin
      fac_s1 <= lk.factory_level;
      fac_s2 <= fac_s1;
    end
  end

  // update word frozen while a request is up, so the core samples a stable word
  always_ff @(posedge upgrade_shift_clock) begin
    if (!link_rst_b) begin
      lk.upd_word  <= rcu_pkg::CTRL_CLEAR;
      lk.req_level <= 1'b0;
    end else begin
      lk.req_level <= fabric_reconfig_request;
      if (update_strobe && fac_s2 && !fabric_reconfig_request) begin
        lk.upd_word <= update_data;
      end
    end
  end
endmodule : rcu_link

// ===== verification/rcu_fabric_model.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// fabric side: user logic driving the update path
// ------------------------------------------------------------
module rcu_fabric_model (
  output logic                       upgrade_shift_clock,
  output logic                       link_rst_b,
  output logic                       update_strobe,
  output logic [rcu_pkg::CTRL_W-1:0] update_data,
  output logic                       fabric_reconfig_request
);
  // user clock runs free, the factory level must cross before a strobe
  initial begin
    upgrade_shift_clock = 1'b0;
    forever #24 upgrade_shift_clock = ~upgrade_shift_clock;
  end

  initial begin
    link_rst_b              = 1'b0;
    update_strobe           = 1'b0;
    update_data             = 39'h0;
    fabric_reconfig_request = 1'b0;
    repeat (4) @(posedge upgrade_shift_clock);
    link_rst_b <= 1'b1;
  end

  task automatic reconfig(input logic [rcu_pkg::CTRL_W-1:0] word);
    repeat (6) @(posedge upgrade_shift_clock);
    update_strobe <= 1'b1;
    update_data   <= word;
    @(posedge upgrade_shift_clock);
    update_strobe <= 1'b0;
    // stale data inverted so a late capture shows up
    update_data   <= ~word;
    repeat (2) @(posedge upgrade_shift_clock);
    fabric_reconfig_request <= 1'b1;
    repeat (16) @(posedge upgrade_shift_clock);
    fabric_reconfig_request <= 1'b0;
    repeat (2) @(posedge upgrade_shift_clock);
  endtask : reconfig
endmodule : rcu_fabric_model

// ===== verification/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic                        clk, rst_b, upgrade_shift_clock, link_rst_b, update_strobe;
  logic                        fabric_reconfig_request, parallel_flash_scheme, crc_error;
  logic                        set_factory_boot_instruction, config_reset_b, config_status_pin;
  logic                        configuration_complete_pin, watchdog_timeout, image_load_done;
  logic                        image_valid, status_view_sel, osc_startup_select;
  logic                        watchdog_enable_bit, image_load_start;
  logic [rcu_pkg::ADDR_W-1:0]  factory_boot_addr_in, boot_address;
  logic [rcu_pkg::CTRL_W-1:0]  update_data, upgrade_control;
  logic [rcu_pkg::STAT_W-1:0]  upgrade_status;
  logic [rcu_pkg::WDC_W-1:0]   watchdog_count;
  logic [rcu_pkg::CAUSE_W-1:0] reconfig_cause;
  logic [1:0]                  master_state;
  int                          mismatches;
  int                          check_count;
  int                          starts;
  int                          start_base;
  localparam logic [38:0] APP_WORD  = {5'h0E, 22'h000123, 12'hABC};
  localparam logic [38:0] APP2_WORD = {5'h0E, 22'h000200, 12'h001};
  localparam logic [4:0]  CAUSE [5] = '{5'h08, 5'h04, 5'h02, 5'h10, 5'h01};

  rcu_ctrl_status u_rcu_ctrl_status (
    .clk(clk), .rst_b(rst_b), .upgrade_shift_clock(upgrade_shift_clock),
    .link_rst_b(link_rst_b), .parallel_flash_scheme(parallel_flash_scheme),
    .set_factory_boot_instruction(set_factory_boot_instruction),
    .factory_boot_addr_in(factory_boot_addr_in),
    .fabric_reconfig_request(fabric_reconfig_request), .update_strobe(update_strobe),
    .update_data(update_data), .config_reset_b(config_reset_b),
    .config_status_pin(config_status_pin),
    .configuration_complete_pin(configuration_complete_pin), .crc_error(crc_error),
    .watchdog_timeout(watchdog_timeout), .image_load_done(image_load_done),
    .image_valid(image_valid), .status_view_sel(status_view_sel),
    .upgrade_control(upgrade_control), .upgrade_status(upgrade_status),
    .boot_address(boot_address), .watchdog_count(watchdog_count),
    .watchdog_enable_bit(watchdog_enable_bit), .osc_startup_select(osc_startup_select),
    .image_load_start(image_load_start), .reconfig_cause(reconfig_cause),
    .master_state(master_state)
  );

  rcu_fabric_model u_rcu_fabric_model (
    .upgrade_shift_clock(upgrade_shift_clock), .link_rst_b(link_rst_b),
    .update_strobe(update_strobe), .update_data(update_data),
    .fabric_reconfig_request(fabric_reconfig_request)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // load start is high one cycle per start, and every cycle while an error holds in load, so it is counted rather than sampled
  always @(posedge clk) begin
    if (image_load_start === 1'b1) starts++;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [38:0] seen, input logic [38:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic stop_test();
    if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  // lands past the edge so registered outputs have settled
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic load(input logic valid);
    @(posedge clk);
    image_load_done <= 1'b1;
    image_valid     <= valid;
    @(posedge clk);
    image_load_done <= 1'b0;
    settle(4);
  endtask : load

  // pins pass a 2FF sync, so they are held longer than the crc pulse
  task automatic trigger(input int i);
    @(posedge clk);
    case (i)
      0: crc_error <= 1'b1;
      1: config_status_pin <= 1'b0;
      2: watchdog_timeout <= 1'b1;
      3: config_reset_b <= 1'b0;
      default: u_rcu_fabric_model.reconfig(APP2_WORD);
    endcase
    repeat ((i == 0) ? 1 : 4) @(posedge clk);
    crc_error         <= 1'b0;
    config_status_pin <= 1'b1;
    watchdog_timeout  <= 1'b0;
    config_reset_b    <= 1'b1;
    settle(8);
  endtask : trigger

  task automatic reset_dut(input logic scheme);
    @(posedge clk);
    rst_b                 <= 1'b0;
    parallel_flash_scheme <= scheme;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    settle(10);
  endtask : reset_dut

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    rst_b                        = 1'b0;
    parallel_flash_scheme        = 1'b0;
    set_factory_boot_instruction = 1'b0;
    factory_boot_addr_in         = 24'h000000;
    config_reset_b               = 1'b1;
    config_status_pin            = 1'b1;
    configuration_complete_pin   = 1'b0;
    crc_error                    = 1'b0;
    watchdog_timeout             = 1'b0;
    image_load_done              = 1'b0;
    image_valid                  = 1'b0;
    status_view_sel              = 1'b0;
    mismatches                   = 0;
    check_count                  = 0;
    @(posedge clk);
    reset_dut(1'b0);
    chk("control", upgrade_control, 39'h0);
    chk("state", master_state, 2'h0);
    load(1'b1);
    chk("state", master_state, 2'h1);
    chk("status_factory", upgrade_status, 32'h40000000);
    u_rcu_fabric_model.reconfig(APP_WORD);
    settle(2);
    chk("control", upgrade_control, APP_WORD);
    chk("cause", reconfig_cause, 5'h01);
    // invalid image with early check on falls back to factory
    load(1'b0);
    chk("state", master_state, 2'h0);
    chk("control", upgrade_control, 39'h0);
    load(1'b1);
    chk("state", master_state, 2'h1);
    // complete pin up before the loader finishes
    u_rcu_fabric_model.reconfig(APP_WORD);
    start_base = starts;
    @(posedge clk);
    configuration_complete_pin <= 1'b1;
    settle(6);
    chk("control", upgrade_control, 39'h0);
    chk("load_start", starts > start_base, 1'b1);
    @(posedge clk);
    configuration_complete_pin <= 1'b0;
    load(1'b1);
    chk("state", master_state, 2'h1);
    for (int i = 0; i < 5; i++) begin
      u_rcu_fabric_model.reconfig(APP_WORD);
      load(1'b1);
      chk("state", master_state, 2'h2);
      @(posedge clk);
      status_view_sel <= 1'b0;
      settle(2);
      chk("status_view1", upgrade_status, {2'h2, 1'b1, 12'hABC, 17'h10000});
      chk("watchdog_count", watchdog_count, {12'hABC, 17'h10000});
      @(posedge clk);
      status_view_sel <= 1'b1;
      settle(2);
      chk("status_view2", upgrade_status, {2'h2, 6'h00, 24'h00048C});
      chk("boot_address", boot_address, 24'h00048C);
      chk("options", {osc_startup_select, watchdog_enable_bit}, 2'h3);
      chk("control_field", upgrade_control[38:34], 5'h0E);
      start_base = starts;
      trigger(i);
      chk("cause", reconfig_cause, CAUSE[i]);
      chk("load_start", starts > start_base, 1'b1);
      chk("control", upgrade_control, 39'h0);
      chk("state", master_state, 2'h0);
      load(1'b1);
    end
    reset_dut(1'b1);
    chk("control_addr", upgrade_control[33:12], 22'h004000);
    chk("boot_address", boot_address, 24'h010000);
    // override, then an error: a cleared field boots the new factory page
    @(posedge clk);
    set_factory_boot_instruction <= 1'b1;
    factory_boot_addr_in         <= 24'h020000;
    @(posedge clk);
    set_factory_boot_instruction <= 1'b0;
    trigger(3);
    chk("cause", reconfig_cause, 5'h10);
    chk("boot_address", boot_address, 24'h020000);
    load(1'b1);
    chk("status_factory", upgrade_status, 32'h40020000);
    stop_test();
  end

  initial begin
    #400000;
    mismatches++;
    stop_test();
  end
endmodule : tb_top
